// *** verilog/status_cksum_regs.sv ***
`timescale 1ns/1ps
`include "status_cksum_cfg.svh"

module status_cksum_regs
    import status_cksum_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire dev_state_s state_in,
    input wire reg_access_s access_in,
    output logic [7:0] rd_data_out,
    output logic rd_hit_out,
    output logic [7:0] checksum_out,
    output logic [7:0] state_flags_out
);

    initial begin
        if (DATA_W != 8) begin
            $error("only 8-bit register data supported");
        end
    end

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
        addr_is = (a == off);
    endfunction : addr_is

    wire logic hit_flags;
    wire logic hit_cksum;
    assign hit_flags = addr_is(access_in.addr, `STATE_FLAGS_OFFSET);
    assign hit_cksum = addr_is(access_in.addr, `CHECKSUM_OFFSET);

    // ----------------------------------------
    // live status assembly
    // ----------------------------------------
    wire logic [2:0] mode_code;
    mode_encoder u_mode (
        .active_in(state_in.active),
        .channel_on_in(state_in.channel_on),
        .mode_out(mode_code)
    );

    logic [7:0] flags_next;
    logic [7:0] flags_reg;
    always_comb begin
        flags_next = 8'h00;
        flags_next[`MODE_FIELD_HI:`MODE_FIELD_LO] = mode_code;
        flags_next[`LOOP_BIT] = state_in.loop_on;
        flags_next[`BIAS_BIT] = state_in.bias_on;
        flags_next[`BOOST_BIT] = state_in.boost_on;
        flags_next[`SOME_FAULT_BIT] = state_in.some_fault;
        flags_next[`ALL_FAULT_BIT] = state_in.all_fault;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            flags_reg <= `STATE_FLAGS_RESET;
        end else if (clk_en_in) begin
            flags_reg <= flags_next;
        end
    end

    // ----------------------------------------
    // write checksum
    // ----------------------------------------
    logic [7:0] cksum_reg;
    logic [7:0] cksum_next;
    wire logic [7:0] cksum_sum;
    assign cksum_sum = cksum_reg + access_in.data;
    always_comb begin
        cksum_next = cksum_reg;
        if (access_in.wr && hit_cksum) begin
            cksum_next = access_in.data;
        end else if (access_in.wr) begin
            cksum_next = cksum_sum;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cksum_reg <= `CHECKSUM_RESET;
        end else if (clk_en_in) begin
            cksum_reg <= cksum_next;
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    logic [7:0] rd_data_reg;
    logic rd_hit_reg;
    wire logic [7:0] rd_sel;
    assign rd_sel = hit_flags ? flags_reg : (hit_cksum ? cksum_reg : 8'h00);

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_reg <= 8'h00;
            rd_hit_reg <= 1'b0;
        end else if (clk_en_in) begin
            rd_data_reg <= access_in.rd ? rd_sel : rd_data_reg;
            rd_hit_reg <= access_in.rd && (hit_flags || hit_cksum);
        end
    end

    assign rd_data_out = rd_data_reg;
    assign rd_hit_out = rd_hit_reg;
    assign checksum_out = cksum_reg;
    assign state_flags_out = flags_reg;

endmodule : status_cksum_regs

// *** verilog/status_cksum_cfg.svh ***
`ifndef STATUS_CKSUM_CFG_SVH
`define STATUS_CKSUM_CFG_SVH

// ----------------------------------------
// offsets and reset values
// ----------------------------------------
`define STATE_FLAGS_OFFSET 8'h7a
`define STATE_FLAGS_RESET 8'h80
`define CHECKSUM_OFFSET 8'h7e
`define CHECKSUM_RESET 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define MODE_FIELD_HI 7
`define MODE_FIELD_LO 5
`define LOOP_BIT 4
`define BIAS_BIT 3
`define BOOST_BIT 2
`define SOME_FAULT_BIT 1
`define ALL_FAULT_BIT 0

// ----------------------------------------
// mode codes
// ----------------------------------------
`define MODE_SLEEP 3'h4
`define MODE_IDLE 3'h6
`define MODE_RUN 3'h7

`endif

// *** verilog/status_cksum_pkg.sv ***
package status_cksum_pkg;

    typedef enum logic [2:0] {
        MODE_SLEEP_E = 3'h4,
        MODE_IDLE_E = 3'h6,
        MODE_RUN_E = 3'h7
    } op_mode_e;

    typedef struct packed {
        logic active;
        logic channel_on;
        logic loop_on;
        logic bias_on;
        logic boost_on;
        logic some_fault;
        logic all_fault;
    } dev_state_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] page;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_access_s;

endpackage : status_cksum_pkg

// *** verilog/mode_encoder.sv ***
`timescale 1ns/1ps
`include "status_cksum_cfg.svh"

module mode_encoder
    import status_cksum_pkg::*;
(
    input wire logic active_in,
    input wire logic channel_on_in,
    output logic [2:0] mode_out
);

    // ----------------------------------------
    // mode code selection
    // ----------------------------------------
    wire logic [2:0] active_code;
    assign active_code = channel_on_in ? `MODE_RUN : `MODE_IDLE;
    assign mode_out = active_in ? active_code : `MODE_SLEEP;

endmodule : mode_encoder

// *** tb/status_cksum_regs_sva.sv ***
`timescale 1ns/1ps
module status_cksum_chk
    import status_cksum_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire dev_state_s state_in,
    input wire reg_access_s access_in,
    input wire logic [7:0] rd_data_out,
    input wire logic rd_hit_out,
    input wire logic [7:0] checksum_out,
    input wire logic [7:0] state_flags_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    wire logic wr_go = clk_en_in & access_in.wr;
    wire logic rd_go = clk_en_in & access_in.rd;
    wire logic to_sum = access_in.addr == 8'h7e;
    wire logic to_flags = access_in.addr == 8'h7a;
    sequence read_flags; rd_go && to_flags; endsequence
    AST_MODE: assert property (clk_en_in |=> state_flags_out[7:5] ==
        (!$past(state_in.active) ? 3'h4 : $past(state_in.channel_on) ? 3'h7 : 3'h6)) else $error("mode");
    AST_RSV: assert property (state_flags_out[7:5] inside {3'h4, 3'h6, 3'h7})
        else $error("reserved");
    AST_BITS: assert property (clk_en_in |=> state_flags_out[4:0] == $past(state_in[4:0]))
        else $error("bits");
    AST_SUM: assert property (wr_go && !to_sum |=> checksum_out == $past(checksum_out) + $past(access_in.data))
        else $error("sum");
    AST_LOAD: assert property (wr_go && to_sum |=> checksum_out == $past(access_in.data))
        else $error("load");
    AST_KEEP: assert property (!wr_go |=> $stable(checksum_out))
        else $error("keep");
    AST_HIT: assert property (read_flags |=> rd_hit_out && rd_data_out == $past(state_flags_out))
        else $error("hit");
    AST_MISS: assert property (rd_go && !to_sum && !to_flags |=> !rd_hit_out && rd_data_out == 8'h00)
        else $error("miss");
endmodule : status_cksum_chk
bind status_cksum_regs status_cksum_chk chk (.*);

// *** tb/host_model.sv ***
`timescale 1ns/1ps
module host_model
    import status_cksum_pkg::*;
(
    input wire logic ref_clk_in,
    output reg_access_s access_out
);
    initial access_out = '0;
    task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        access_out <= '{wr: w, rd: !w, page: 7'h00, addr: a, data: d};
        @(posedge ref_clk_in);
        access_out <= '0;
    endtask : xfer
endmodule : host_model

// *** tb/device_status_and_write_checksum_test.sv ***
`timescale 1ns/1ps
module device_status_and_write_checksum_test
    import status_cksum_pkg::*;
;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic clk_en_in = 1'b1;
    dev_state_s state_in = '0;
    reg_access_s access_in;
    logic [7:0] rd_data_out, checksum_out, state_flags_out;
    logic rd_hit_out;
    int n_mismatch = 0;
    int comparisons = 0;
    always #50 ref_clk_in = ~ref_clk_in;
    host_model host (.ref_clk_in(ref_clk_in), .access_out(access_in));
    status_cksum_regs uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in), .state_in(state_in),
        .access_in(access_in), .rd_data_out(rd_data_out), .rd_hit_out(rd_hit_out),
        .checksum_out(checksum_out), .state_flags_out(state_flags_out));
    task results;
        if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic h);
        host.xfer(1'b0, a, 8'h00);
        #1;
        comparisons++;
        if (rd_data_out !== d || rd_hit_out !== h) begin
            n_mismatch++;
            $display("mismatch %0t read %h got %h", $time, a, rd_data_out);
        end
    endtask : rd
    task automatic sum_is(input logic [7:0] d);
        #1;
        comparisons++;
        if (checksum_out !== d) begin
            n_mismatch++;
            $display("mismatch %0t checksum got %h", $time, checksum_out);
        end
    endtask : sum_is
    initial begin
        repeat (5000) @(posedge ref_clk_in);
        n_mismatch++;
        results();
    end
    initial begin
        repeat (20) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        rd(8'h7a, 8'h80, 1'b1);
        rd(8'h7e, 8'h00, 1'b1);
        for (int i = 0; i < 128; i++) begin
            @(posedge ref_clk_in);
            state_in <= dev_state_s'(i);
            @(posedge ref_clk_in);
            rd(8'h7a, {i[6] ? (i[5] ? 3'h7 : 3'h6) : 3'h4, i[4:0]}, 1'b1);
        end
        host.xfer(1'b1, 8'h7e, 8'hf0);
        sum_is(8'hf0);
        host.xfer(1'b1, 8'h10, 8'h20);
        sum_is(8'h10);
        host.xfer(1'b1, 8'h7a, 8'h00);
        sum_is(8'h10);
        @(posedge ref_clk_in);
        clk_en_in <= 1'b0;
        host.xfer(1'b1, 8'h10, 8'h11);
        clk_en_in <= 1'b1;
        sum_is(8'h10);
        rd(8'h7a, 8'hff, 1'b1);
        rd(8'h55, 8'h00, 1'b0);
        rd(8'h7e, 8'h10, 1'b1);
        @(posedge ref_clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        rd(8'h7e, 8'h00, 1'b1);
        rd(8'h7a, 8'hff, 1'b1);
        results();
    end
endmodule : device_status_and_write_checksum_test
